//--- ldp_pkg.sv
// ldp_pkg: register map, field layout, reset values and timing counts
// assumes a 100 MHz system clock
package ldp_pkg;
   localparam logic [6:0] CHIP_ADDR        = 7'h36;
   localparam logic [7:0] GP_CTRL_OFS      = 8'h10;
   localparam logic [7:0] RAMP_STEP_OFS    = 8'h20;
   localparam logic [7:0] GAIN_DELAY_OFS   = 8'h60;
   localparam logic [7:0] MAIN_LEVEL_OFS   = 8'ha0;
   localparam logic [7:0] AUX_LEVEL_OFS    = 8'hb0;
   localparam logic [7:0] IND_LEVEL_OFS    = 8'hc0;
   localparam logic [7:0] GP_CTRL_RST      = 8'h00;
   localparam logic [7:0] RAMP_STEP_RST    = 8'hf0;
   localparam logic [7:0] GAIN_DELAY_RST   = 8'hfc;
   localparam logic [7:0] MAIN_LEVEL_RST   = 8'he0;
   localparam logic [7:0] AUX_LEVEL_RST    = 8'hf8;
   localparam logic [7:0] IND_LEVEL_RST    = 8'hf8;
   // general purpose control bit positions
   localparam int GP_MAIN_ON_BIT    = 0;
   localparam int GP_AUX_ON_BIT     = 1;
   localparam int GP_IND_ON_BIT     = 2;
   localparam int GP_ONE_OFF_BIT    = 3;
   localparam int GP_TWO_OFF_BIT    = 4;
   localparam int GP_ONE_MAIN_BIT   = 5;
   localparam int GP_TWO_MAIN_BIT   = 6;
   localparam int MAIN_CODE_W       = 5;
   localparam int SUB_CODE_W        = 3;
   // ramp step times in microseconds
   localparam int STEP0_US          = 100;
   localparam int STEP1_US          = 25000;
   localparam int STEP2_US          = 50000;
   localparam int STEP3_US          = 100000;
   localparam int CLK_MHZ           = 100;
   localparam int STEP0_CYC         = STEP0_US * CLK_MHZ;
   localparam int STEP1_CYC         = STEP1_US * CLK_MHZ;
   localparam int STEP2_CYC         = STEP2_US * CLK_MHZ;
   localparam int STEP3_CYC         = STEP3_US * CLK_MHZ;
   // gain transition delay, shortest figure of each range, in us
   localparam int GDLY0_US          = 3000;
   localparam int GDLY1_US          = 1500;
   localparam int GDLY2_US          = 400;
   localparam int GDLY3_US          = 60;
   localparam int GDLY0_CYC         = GDLY0_US * CLK_MHZ;
   localparam int GDLY1_CYC         = GDLY1_US * CLK_MHZ;
   localparam int GDLY2_CYC         = GDLY2_US * CLK_MHZ;
   localparam int GDLY3_CYC         = GDLY3_US * CLK_MHZ;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_ADDR  = 3'b001,
      ST_INDEX = 3'b010,
      ST_DATA  = 3'b011,
      ST_READ  = 3'b100,
      ST_SKIP  = 3'b101
   } ldp_state_e;
endpackage : ldp_pkg

//--- ldp_reg_if.sv
// ldp_reg_if: register write strobe and read data between port and bank
// assumes one clock domain for both ends
`timescale 1ns/10ps
`default_nettype none
interface ldp_reg_if;
   logic       wr_stb;
   logic [7:0] index;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport port (output wr_stb, output index, output wdata, input rdata);
   modport bank (input wr_stb, input index, input wdata, output rdata);
endinterface : ldp_reg_if
`default_nettype wire

//--- ldp_bank.sv
// ldp_bank: control registers, main group ramp, sink level outputs
// assumes writes arrive as single-cycle strobes on clk
`timescale 1ns/10ps
`default_nettype none
module ldp_bank
   import ldp_pkg::*;
#(
   parameter int STEP_CYC0 = STEP0_CYC,
   parameter int STEP_CYC1 = STEP1_CYC,
   parameter int STEP_CYC2 = STEP2_CYC,
   parameter int STEP_CYC3 = STEP3_CYC
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic         hw_en,
   // register access
   ldp_reg_if.bank           rif,
   // sink controls
   output logic [4:0]        main_level,
   output logic [2:0]        aux_level,
   output logic [2:0]        indicator_level,
   output logic [1:0]        gain_delay_select,
   output logic [7:0]        gp_ctrl
);
   logic [7:0]  gp_r, gp_nxt, rs_r, rs_nxt, gd_r, gd_nxt;
   logic [7:0]  ma_r, ma_nxt, au_r, au_nxt, ic_r, ic_nxt;
   logic [4:0]  cur_r, cur_nxt;
   logic        live_r, live_nxt;
   logic [23:0] tmr_r, tmr_nxt;
   logic [23:0] step_len;
   logic [4:0]  target;

   always_comb begin
      gp_nxt = gp_r;
      rs_nxt = rs_r;
      gd_nxt = gd_r;
      ma_nxt = ma_r;
      au_nxt = au_r;
      ic_nxt = ic_r;
      if (!hw_en) begin
         gp_nxt = GP_CTRL_RST;
         rs_nxt = RAMP_STEP_RST;
         gd_nxt = GAIN_DELAY_RST;
         ma_nxt = MAIN_LEVEL_RST;
         au_nxt = AUX_LEVEL_RST;
         ic_nxt = IND_LEVEL_RST;
      end else if (rif.wr_stb) begin
         unique case (rif.index)
            GP_CTRL_OFS:    gp_nxt = rif.wdata;
            RAMP_STEP_OFS:  rs_nxt = {6'h3c, rif.wdata[1:0]};
            GAIN_DELAY_OFS: gd_nxt = {6'h3f, rif.wdata[1:0]};
            MAIN_LEVEL_OFS: ma_nxt = {3'h7, rif.wdata[4:0]};
            AUX_LEVEL_OFS:  au_nxt = {5'h1f, rif.wdata[2:0]};
            IND_LEVEL_OFS:  ic_nxt = {5'h1f, rif.wdata[2:0]};
            default: ;
         endcase
      end
   end

   always_comb begin
      unique case (rs_r[1:0])
         2'b00:   step_len = 24'(STEP_CYC0);
         2'b01:   step_len = 24'(STEP_CYC1);
         2'b10:   step_len = 24'(STEP_CYC2);
         2'b11:   step_len = 24'(STEP_CYC3);
      endcase
   end

   // ramp walks one code per step toward level or zero
   assign target = gp_r[GP_MAIN_ON_BIT] ? ma_r[4:0] : 5'h00;
   always_comb begin
      cur_nxt  = cur_r;
      live_nxt = live_r;
      tmr_nxt  = tmr_r;
      if (!hw_en) begin
         cur_nxt  = 5'h00;
         live_nxt = 1'b0;
         tmr_nxt  = 24'h000000;
      end else if (gp_r[GP_MAIN_ON_BIT] && !live_r) begin
         live_nxt = 1'b1;
         tmr_nxt  = 24'h000000;
      end else if (live_r && cur_r != target) begin
         if (tmr_r + 24'h000001 >= step_len) begin
            tmr_nxt = 24'h000000;
            cur_nxt = (cur_r < target) ? cur_r + 5'h01
                                       : cur_r - 5'h01;
         end else begin
            tmr_nxt = tmr_r + 24'h000001;
         end
      end else if (live_r && !gp_r[GP_MAIN_ON_BIT] && cur_r == 5'h00) begin
         live_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         gp_r   <= GP_CTRL_RST;
         rs_r   <= RAMP_STEP_RST;
         gd_r   <= GAIN_DELAY_RST;
         ma_r   <= MAIN_LEVEL_RST;
         au_r   <= AUX_LEVEL_RST;
         ic_r   <= IND_LEVEL_RST;
         cur_r  <= 5'h00;
         live_r <= 1'b0;
         tmr_r  <= 24'h000000;
      end else begin
         gp_r   <= gp_nxt;
         rs_r   <= rs_nxt;
         gd_r   <= gd_nxt;
         ma_r   <= ma_nxt;
         au_r   <= au_nxt;
         ic_r   <= ic_nxt;
         cur_r  <= cur_nxt;
         live_r <= live_nxt;
         tmr_r  <= tmr_nxt;
      end
   end

   always_comb begin
      unique case (rif.index)
         GP_CTRL_OFS:    rif.rdata = gp_r;
         RAMP_STEP_OFS:  rif.rdata = rs_r;
         GAIN_DELAY_OFS: rif.rdata = gd_r;
         MAIN_LEVEL_OFS: rif.rdata = ma_r;
         AUX_LEVEL_OFS:  rif.rdata = au_r;
         IND_LEVEL_OFS:  rif.rdata = ic_r;
         default:        rif.rdata = 8'h00;
      endcase
   end

   // main level stays live through ramp-down; aux levels apply at once
   assign main_level        = cur_r;
   assign aux_level         = au_r[2:0];
   assign indicator_level   = ic_r[2:0];
   assign gain_delay_select = gd_r[1:0];
   assign gp_ctrl           = {gp_r[7:1], live_r};
endmodule : ldp_bank
`default_nettype wire

//--- ldp_top.sv
// ldp_top: two-wire target port and led driver control outputs
// Summary of operation
// - data changes only while clock is low
// - high-to-low data with clock high starts
// - low-to-high data with clock high stops
// - busy from start until stop
// - repeated start restarts address reception
// - bytes are eight bits, msb first
// - drive data low for the ninth pulse
// - acknowledge address, index and data bytes
// - respond only to address 0110110
// - index byte then data byte stored
// - general register holds enables, shutdowns, routing
// - main level five bits, top bits ones
// - aux level three bits, top bits ones
// - indicator level three bits, top ones
// - main codes map to exponential table
// - sub codes map ten to seventy, hundred
// - ramp step field picks four times
// - ramp affects main group only
// - delay field picks four gain delays
// - enable pin low resets all registers
// - routing bit picks main or aux group
// - main level ramps one code per step
// assumes scl and sda pins are asynchronous to clk
`timescale 1ns/10ps
`default_nettype none
module ldp_top
   import ldp_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // pins
   input  wire logic        hardware_enable_pin,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   // sink controls
   output logic [16:0]      main_scale_permille,
   output logic [9:0]       aux_scale_permille,
   output logic [9:0]       indicator_scale_permille,
   output logic [5:0]       main_sink_on,
   output logic [2:0]       aux_sink_on,
   output logic             indicator_on,
   output logic [1:0]       gain_delay_select,
   output logic [23:0]      gain_delay_cycles,
   output logic             bus_busy
);
   ldp_reg_if rif ();

   // synchronised pins and edges
   logic [1:0] scl_s_r, sda_s_r, hw_s_r;
   logic       scl_d_r, sda_d_r;
   logic       scl, sda, hw_en, scl_rise, scl_fall, start_c, stop_c;

   // transfer state
   ldp_state_e st_r, st_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic [7:0] sh_r, sh_nxt, idx_r, idx_nxt, wd_r, wd_nxt, tx_r, tx_nxt;
   logic       ack_r, ack_nxt, busy_r, busy_nxt, wr_r, wr_nxt;
   logic       drv_r, drv_nxt;

   // from the register bank
   logic [4:0] main_code;
   logic [2:0] aux_code, ind_code;
   logic [7:0] gp;

   // pins cross two flops; only the second stage is read
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         scl_s_r <= 2'h3;
         sda_s_r <= 2'h3;
         hw_s_r  <= 2'h0;
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_s_r <= {scl_s_r[0], scl_in};
         sda_s_r <= {sda_s_r[0], sda_in};
         hw_s_r  <= {hw_s_r[0], hardware_enable_pin};
         scl_d_r <= scl_s_r[1];
         sda_d_r <= sda_s_r[1];
      end
   end
   assign scl      = scl_s_r[1];
   assign sda      = sda_s_r[1];
   assign hw_en    = hw_s_r[1];

   // edges compare the second stage with its one-clock-delayed copy
   assign scl_rise = scl & ~scl_d_r;
   assign scl_fall = ~scl & scl_d_r;
   assign start_c  = scl & scl_d_r & sda_d_r & ~sda;
   assign stop_c   = scl & scl_d_r & ~sda_d_r & sda;

   // bit engine: sample on scl rise, change sda only on scl fall
   always_comb begin
      st_nxt  = st_r;
      cnt_nxt = cnt_r;
      sh_nxt  = sh_r;
      idx_nxt = idx_r;
      wd_nxt  = wd_r;
      tx_nxt  = tx_r;
      ack_nxt = ack_r;
      busy_nxt = busy_r;
      wr_nxt  = 1'b0;
      drv_nxt = drv_r;

      if (!hw_en) begin
         // pin low drops the frame
         st_nxt   = ST_IDLE;
         busy_nxt = 1'b0;
         drv_nxt  = 1'b0;
         ack_nxt  = 1'b0;
         cnt_nxt  = 4'h0;
      end else if (start_c) begin
         // repeated start acts as a first
         st_nxt   = ST_ADDR;
         busy_nxt = 1'b1;
         cnt_nxt  = 4'h0;
         ack_nxt  = 1'b0;
         drv_nxt  = 1'b0;
      end else if (stop_c) begin
         // stop drops any pull-down
         st_nxt   = ST_IDLE;
         busy_nxt = 1'b0;
         drv_nxt  = 1'b0;
         ack_nxt  = 1'b0;
      end else if (scl_rise && st_r != ST_IDLE && st_r != ST_SKIP) begin
         // bits 1..8, then the ack slot
         if (cnt_r < 4'h8) begin
            sh_nxt  = {sh_r[6:0], sda};
            cnt_nxt = cnt_r + 4'h1;
         end else begin
            cnt_nxt = 4'h0;                              // ninth pulse done
            if (st_r == ST_READ && sda)
               st_nxt = ST_SKIP;                         // master nack ends read
         end
      end else if (scl_fall && st_r != ST_IDLE && st_r != ST_SKIP) begin
         // pull-down moves only with scl low
         drv_nxt = 1'b0;
         if (cnt_r == 4'h8 && st_r != ST_READ) begin
            // byte in: ack or not
            unique case (st_r)
               ST_ADDR: begin
                  if (sh_r[7:1] == CHIP_ADDR) begin
                     ack_nxt = 1'b1;
                     st_nxt  = sh_r[0] ? ST_READ : ST_INDEX;
                     tx_nxt  = rif.rdata;
                  end else begin
                     st_nxt = ST_SKIP;
                  end
               end
               ST_INDEX: begin
                  ack_nxt = 1'b1;
                  idx_nxt = sh_r;
                  st_nxt  = ST_DATA;
               end
               ST_DATA: begin
                  ack_nxt = 1'b1;
                  wd_nxt  = sh_r;
                  wr_nxt  = 1'b1;
               end
               default: ;
            endcase
            drv_nxt = ack_nxt;
         end else if (st_r == ST_READ && cnt_r < 4'h8) begin
            // ones shifted in free the line
            drv_nxt = ~tx_r[7];
            tx_nxt  = {tx_r[6:0], 1'b1};
         end else begin
            ack_nxt = 1'b0;
            if (st_r == ST_READ)
               tx_nxt = rif.rdata;
         end
      end
   end

   // registers only; decisions are above
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_r   <= ST_IDLE;
         cnt_r  <= 4'h0;
         sh_r   <= 8'h00;
         idx_r  <= 8'h00;
         wd_r   <= 8'h00;
         tx_r   <= 8'hff;
         ack_r  <= 1'b0;
         busy_r <= 1'b0;
         wr_r   <= 1'b0;
         drv_r  <= 1'b0;
      end else begin
         st_r   <= st_nxt;
         cnt_r  <= cnt_nxt;
         sh_r   <= sh_nxt;
         idx_r  <= idx_nxt;
         wd_r   <= wd_nxt;
         tx_r   <= tx_nxt;
         ack_r  <= ack_nxt;
         busy_r <= busy_nxt;
         wr_r   <= wr_nxt;
         drv_r  <= drv_nxt;
      end
   end

   // open drain: only ever pull low
   assign sda_out    = 1'b0;
   assign sda_oe     = drv_r;
   assign bus_busy   = busy_r;

   assign rif.wr_stb = wr_r;
   assign rif.index  = idx_r;
   assign rif.wdata  = wd_r;

   ldp_bank u_bank (
      .clk               (clk),
      .nrst              (nrst),
      .hw_en             (hw_en),
      .rif               (rif),
      .main_level        (main_code),
      .aux_level         (aux_code),
      .indicator_level   (ind_code),
      .gain_delay_select (gain_delay_select),
      .gp_ctrl           (gp)
   );

   // brightness in thousandths of a percent of full scale
   // 17 bits: full scale is 100000
   always_comb begin
      unique case (main_code)
         5'h00: main_scale_permille = 17'd125;
         5'h01: main_scale_permille = 17'd313;
         5'h02: main_scale_permille = 17'd625;
         5'h03: main_scale_permille = 17'd1000;
         5'h04: main_scale_permille = 17'd1125;
         5'h05: main_scale_permille = 17'd1313;
         5'h06: main_scale_permille = 17'd1688;
         5'h07: main_scale_permille = 17'd2063;
         5'h08: main_scale_permille = 17'd2438;
         5'h09: main_scale_permille = 17'd2813;
         5'h0a: main_scale_permille = 17'd3125;
         5'h0b: main_scale_permille = 17'd3750;
         5'h0c: main_scale_permille = 17'd4375;
         5'h0d: main_scale_permille = 17'd5250;
         5'h0e: main_scale_permille = 17'd6250;
         5'h0f: main_scale_permille = 17'd7500;
         5'h10: main_scale_permille = 17'd8750;
         5'h11: main_scale_permille = 17'd10000;
         5'h12: main_scale_permille = 17'd12500;
         5'h13: main_scale_permille = 17'd15000;
         5'h14: main_scale_permille = 17'd16875;
         5'h15: main_scale_permille = 17'd18750;
         5'h16: main_scale_permille = 17'd22500;
         5'h17: main_scale_permille = 17'd26250;
         5'h18: main_scale_permille = 17'd31250;
         5'h19: main_scale_permille = 17'd37500;
         5'h1a: main_scale_permille = 17'd43750;
         5'h1b: main_scale_permille = 17'd52500;
         5'h1c: main_scale_permille = 17'd61250;
         5'h1d: main_scale_permille = 17'd70000;
         5'h1e: main_scale_permille = 17'd87500;
         5'h1f: main_scale_permille = 17'd100000;
      endcase
   end

   // sub groups in tenths of a percent: 100..700 then 1000
   assign aux_scale_permille = (&aux_code) ? 10'd1000
                              : 10'(({7'h00, aux_code} + 10'd1) * 10'd100);

   assign indicator_scale_permille = (&ind_code) ? 10'd1000
                              : 10'(({7'h00, ind_code} + 10'd1) * 10'd100);

   // routing of the two extra sinks
   always_comb begin
      main_sink_on = {2'b00, {4{gp[GP_MAIN_ON_BIT]}}};
      aux_sink_on  = {2'b00, gp[GP_AUX_ON_BIT]};
      main_sink_on[4] = gp[GP_ONE_MAIN_BIT] & gp[GP_MAIN_ON_BIT]
                        & ~gp[GP_ONE_OFF_BIT];
      main_sink_on[5] = gp[GP_TWO_MAIN_BIT] & gp[GP_MAIN_ON_BIT]
                        & ~gp[GP_TWO_OFF_BIT];
      aux_sink_on[1]  = ~gp[GP_ONE_MAIN_BIT] & gp[GP_AUX_ON_BIT]
                        & ~gp[GP_ONE_OFF_BIT];
      aux_sink_on[2]  = ~gp[GP_TWO_MAIN_BIT] & gp[GP_AUX_ON_BIT]
                        & ~gp[GP_TWO_OFF_BIT];
   end

   assign indicator_on = gp[GP_IND_ON_BIT];

   // shortest figure of each delay range
   always_comb begin
      unique case (gain_delay_select)
         2'b00: gain_delay_cycles = 24'(GDLY0_CYC);
         2'b01: gain_delay_cycles = 24'(GDLY1_CYC);
         2'b10: gain_delay_cycles = 24'(GDLY2_CYC);
         2'b11: gain_delay_cycles = 24'(GDLY3_CYC);
      endcase
   end
endmodule : ldp_top
`default_nettype wire

//--- ldp_chk_checker.sv
// ldp_chk: bus and sink output properties of the led driver port
// assumes binding onto ldp_top, pins sampled on clk
`timescale 1ns/10ps
`default_nettype none
module ldp_chk
   import ldp_pkg::*;
(
   // clock and reset
   input wire logic        clk,
   input wire logic        nrst,
   // pins
   input wire logic        hardware_enable_pin,
   input wire logic        scl_in,
   input wire logic        sda_in,
   input wire logic        sda_out,
   input wire logic        sda_oe,
   // sink controls
   input wire logic [16:0] main_scale_permille,
   input wire logic [9:0]  aux_scale_permille,
   input wire logic [5:0]  main_sink_on,
   input wire logic [2:0]  aux_sink_on,
   input wire logic        indicator_on,
   input wire logic [1:0]  gain_delay_select,
   input wire logic [23:0] gain_delay_cycles,
   input wire logic        bus_busy
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   logic [23:0] gdly;
   // minimum of each delay range at 100 MHz
   assign gdly = (gain_delay_select == 2'd0) ? 24'd300000 :
                 (gain_delay_select == 2'd1) ? 24'd150000 :
                 (gain_delay_select == 2'd2) ? 24'd40000 : 24'd6000;
   sequence start_s;
      scl_in && $fell(sda_in);
   endsequence
   sequence stop_s;
      scl_in && $rose(sda_in);
   endsequence
   start_busy_a: assert property (start_s |-> ##[2:6] bus_busy)
      else $error("busy not raised after start");
   stop_idle_a: assert property (stop_s |-> ##[2:6] !bus_busy)
      else $error("busy not cleared after stop");
   oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("data pin changed while clock high");
   oe_low_a: assert property (sda_oe |-> !sda_out)
      else $error("driven data pin not low");
   oe_idle_a: assert property (!bus_busy |-> !sda_oe)
      else $error("data pin driven on idle bus");
   ack_hold_a: assert property ($rose(sda_oe) |-> sda_oe [*8])
      else $error("pull-down shorter than a clock pulse");
   hw_off_a: assert property (!hardware_enable_pin [*5] |->
      main_sink_on == 6'h00 && aux_sink_on == 3'h0 && !indicator_on)
      else $error("sinks on while enable pin low");
   route_one_a: assert property (!(main_sink_on[4] && aux_sink_on[1]) &&
      !(main_sink_on[5] && aux_sink_on[2]))
      else $error("extra sink in two groups");
   aux_scale_a: assert property (aux_scale_permille == 10'd1000 ||
      (aux_scale_permille inside {[10'd100:10'd700]} &&
      aux_scale_permille % 10'd100 == 10'd0))
      else $error("aux scale off the linear table");
   gain_map_a: assert property (gain_delay_cycles == gdly)
      else $error("gain delay count wrong for field");
   ramp_step_a: assert property ($changed(main_scale_permille) |=>
      $stable(main_scale_permille) [*8])
      else $error("main level moved twice in a step");
endmodule : ldp_chk
bind ldp_top ldp_chk i_ldp_chk (.clk(clk), .nrst(nrst),
   .hardware_enable_pin(hardware_enable_pin), .scl_in(scl_in),
   .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .main_scale_permille(main_scale_permille),
   .aux_scale_permille(aux_scale_permille), .main_sink_on(main_sink_on),
   .aux_sink_on(aux_sink_on), .indicator_on(indicator_on),
   .gain_delay_select(gain_delay_select),
   .gain_delay_cycles(gain_delay_cycles), .bus_busy(bus_busy));
`default_nettype wire

//--- ldp_master.sv
// ldp_master: behavioural two-wire bus master, 125 ns clock period
// assumes an external pull-up; sda_pull high pulls the line low
`timescale 1ns/10ps
`default_nettype none
module ldp_master
   import ldp_pkg::*;
(
   // bus pins
   output logic      scl,
   output logic      sda_pull,
   input  wire logic sda
);
   localparam realtime Q = 31.25;
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   // data moves a quarter period into the low phase only
   task automatic bit_out(input logic b);
      #Q sda_pull = !b;
      #Q scl = 1'b1;
      #(2 * Q) scl = 1'b0;
   endtask : bit_out
   task automatic bit_in(output logic b);
      #Q sda_pull = 1'b0;
      #Q scl = 1'b1;
      #Q b = sda;
      #Q scl = 1'b0;
   endtask : bit_in
   task automatic start;
      #Q sda_pull = 1'b0;
      #Q scl = 1'b1;
      #Q sda_pull = 1'b1;
      #Q scl = 1'b0;
   endtask : start
   task automatic stop;
      #Q sda_pull = 1'b1;
      #Q scl = 1'b1;
      #Q sda_pull = 1'b0;
      #Q;
   endtask : stop
   task automatic put_byte(input logic [7:0] v, output logic ack);
      for (int k = 7; k >= 0; k--) bit_out(v[k]);
      bit_in(ack);
      ack = !ack;
   endtask : put_byte
   task automatic wr(input logic [6:0] ad, input logic [7:0] ix,
                     input logic [7:0] d, output logic [2:0] acks);
      start();
      put_byte({ad, 1'b0}, acks[2]);
      put_byte(ix, acks[1]);
      put_byte(d, acks[0]);
      stop();
   endtask : wr
   task automatic rd(input logic [7:0] ix, output logic [7:0] v);
      logic a;
      start();
      put_byte({CHIP_ADDR, 1'b0}, a);
      put_byte(ix, a);
      start();
      put_byte({CHIP_ADDR, 1'b1}, a);
      for (int k = 7; k >= 0; k--) bit_in(v[k]);
      bit_out(1'b1);
      stop();
   endtask : rd
endmodule : ldp_master
`default_nettype wire

//--- tb.sv
// tb: register port scenarios through the two-wire master model
// assumes ldp_top at 100 MHz with ldp_master on the bus
`timescale 1ns/10ps
`default_nettype none
module tb;
   import ldp_pkg::*;
   logic        clk = 1'b0;
   logic        nrst;
   logic        hw_en;
   logic        m_scl;
   logic        m_pull;
   wire         sda_w;
   logic        sda_out;
   logic        sda_oe;
   logic [16:0] main_scale;
   logic [9:0]  aux_scale;
   logic [9:0]  ind_scale;
   logic [5:0]  main_on;
   logic [2:0]  aux_on;
   logic        ind_on;
   logic [1:0]  gsel;
   logic [23:0] gcyc;
   logic        busy;
   int          n_fail = 0;
   int          tests_run = 0;
   int          seed;
   logic [2:0]  c;
   logic [2:0]  a;
   logic [7:0]  g;
   logic [7:0]  ofs [6] = '{8'h10, 8'h20, 8'h60, 8'ha0, 8'hb0, 8'hc0};
   logic [7:0]  por [6] = '{8'h00, 8'hf0, 8'hfc, 8'he0, 8'hf8, 8'hf8};
   logic [23:0] gd [4] = '{24'd300000, 24'd150000, 24'd40000, 24'd6000};
   always #5 clk = ~clk;
   // line pulled up unless either party pulls it low
   assign sda_w = !m_pull && (!sda_oe || sda_out);
   ldp_top i_ldp_top (.clk(clk), .nrst(nrst), .hardware_enable_pin(hw_en),
      .scl_in(m_scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
      .main_scale_permille(main_scale), .aux_scale_permille(aux_scale),
      .indicator_scale_permille(ind_scale), .main_sink_on(main_on),
      .aux_sink_on(aux_on), .indicator_on(ind_on), .gain_delay_select(gsel),
      .gain_delay_cycles(gcyc), .bus_busy(busy));
   ldp_master i_ldp_master (.scl(m_scl), .sda_pull(m_pull), .sda(sda_w));
   function automatic logic [9:0] sub_pm(input logic [2:0] k);
      return (k == 3'd7) ? 10'd1000 : 10'd100 * (10'(k) + 10'd1);
   endfunction : sub_pm
   function automatic logic [2:0] aux_exp(input logic [7:0] v);
      return {3{v[1]}} & {!v[6] && !v[4], !v[5] && !v[3], 1'b1};
   endfunction : aux_exp
   task automatic chk(input string nm, input logic [23:0] e,
                      input logic [23:0] s);
      tests_run++;
      if (s !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic w(input logic [7:0] ix, input logic [7:0] d);
      logic [2:0] k;
      i_ldp_master.wr(CHIP_ADDR, ix, d, k);
      chk("write acks", 24'h7, 24'(k));
   endtask : w
   task automatic r(input logic [7:0] ix, input logic [7:0] e);
      logic [7:0] v;
      i_ldp_master.rd(ix, v);
      chk("read data", 24'(e), 24'(v));
   endtask : r
   task automatic close_out;
      $display("counts: tests_run %0d n_fail %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : close_out
   initial begin
      #1000000;
      n_fail++;
      close_out();
   end
   initial begin
      seed = 32'h3179021c;
      nrst = 1'b0;
      hw_en = 1'b1;
      repeat (12) @(negedge clk);
      nrst = 1'b1;
      repeat (5) @(negedge clk);
      for (int k = 0; k < 6; k++) r(ofs[k], por[k]);
      $display("done: reset values");
      for (int k = 0; k < 6; k++) begin
         c = (k < 2) ? 3'(k * 7) : 3'($random(seed));
         w(AUX_LEVEL_OFS, {5'h00, c});
         w(IND_LEVEL_OFS, {5'h00, ~c});
         chk("aux scale", 24'(sub_pm(c)), 24'(aux_scale));
         chk("ind scale", 24'(sub_pm(~c)), 24'(ind_scale));
         r(AUX_LEVEL_OFS, {5'h1f, c});
         r(IND_LEVEL_OFS, {5'h1f, ~c});
      end
      g = 8'($random(seed));
      w(MAIN_LEVEL_OFS, {3'h0, g[4:0]});
      r(MAIN_LEVEL_OFS, {3'h7, g[4:0]});
      w(RAMP_STEP_OFS, 8'h03);
      r(RAMP_STEP_OFS, 8'hf3);
      w(RAMP_STEP_OFS, 8'h00);
      for (int k = 0; k < 4; k++) begin
         w(GAIN_DELAY_OFS, 8'(k));
         chk("gain select", 24'(k), 24'(gsel));
         chk("gain cycles", gd[k], gcyc);
      end
      $display("done: levels and delays");
      for (int k = 0; k < 6; k++) begin
         g = (k < 3) ? 8'h26 << k : 8'($random(seed)) & 8'h7e;
         w(GP_CTRL_OFS, g);
         chk("aux sinks", 24'(aux_exp(g)), 24'(aux_on));
         chk("ind on", 24'(g[2]), 24'(ind_on));
         chk("main sinks", 24'h0, 24'(main_on));
         r(GP_CTRL_OFS, g);
      end
      i_ldp_master.wr(7'h37, AUX_LEVEL_OFS, 8'h00, a);
      chk("wrong address acks", 24'h0, 24'(a));
      r(AUX_LEVEL_OFS, {5'h1f, c});
      w(8'h55, 8'h12);
      r(8'h55, 8'h00);
      $display("done: routing and refusals");
      i_ldp_master.start();
      i_ldp_master.put_byte({CHIP_ADDR, 1'b0}, a[2]);
      i_ldp_master.put_byte(IND_LEVEL_OFS, a[1]);
      chk("busy in frame", 24'h1, 24'(busy));
      i_ldp_master.start();
      i_ldp_master.put_byte({CHIP_ADDR, 1'b0}, a[0]);
      i_ldp_master.put_byte(AUX_LEVEL_OFS, a[1]);
      i_ldp_master.put_byte(8'h02, a[2]);
      i_ldp_master.stop();
      repeat (10) @(negedge clk);
      chk("restart acks", 24'h7, 24'(a));
      chk("busy after stop", 24'h0, 24'(busy));
      r(AUX_LEVEL_OFS, 8'hfa);
      r(IND_LEVEL_OFS, {5'h1f, ~c});
      $display("done: repeated start");
      w(MAIN_LEVEL_OFS, 8'h01);
      w(GP_CTRL_OFS, 8'h21);
      repeat (3000) @(negedge clk);
      chk("ramp first code", 24'd125, 24'(main_scale));
      chk("main sinks on", 24'h1f, 24'(main_on));
      repeat (12000) @(negedge clk);
      chk("ramp next code", 24'd313, 24'(main_scale));
      $display("done: ramp");
      hw_en = 1'b0;
      repeat (10) @(negedge clk);
      chk("sinks off", 24'h0, 24'(main_on));
      hw_en = 1'b1;
      repeat (5) @(negedge clk);
      r(GP_CTRL_OFS, 8'h00);
      r(AUX_LEVEL_OFS, 8'hf8);
      $display("done: enable pin");
      close_out();
   end
endmodule : tb
`default_nettype wire
